// ### hdl/sst_sequencer.sv
// Scan/step trigger sequencer with Avalon-MM register slave and reading buffer
`default_nettype none
`include "sst_cfg.svh"

module sst_sequencer
  import sst_pkg::*;
#(
  parameter int        DEPTH      = 1024,
  parameter int        PULSE_CYC  = `SST_PULSE_CYC,
  parameter int        TICK_CYC   = `SST_TICK_CYC
) (
  input  wire logic                  clk_i,
  input  wire logic                  rst_i,
  input  wire sst_av_req_t           av_req_i,
  output var  sst_av_rsp_t           av_rsp_o,
  input  wire logic                  trig_in_i,
  output logic                       trig_out_o,
  output logic                       meas_start_o,
  input  wire logic                  meas_done_i,
  input  wire logic [`SST_RDG_W-1:0] meas_data_i,
  output logic [`SST_CHAN_W-1:0]     chan_o,
  output logic                       ref_junction_o,
  output logic                       busy_o
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    sst_state_t             state;
    logic                   step;
    logic                   timer_sel;
    logic [`SST_CHAN_W-1:0] min_ch;
    logic [`SST_CHAN_W-1:0] max_ch;
    logic [`SST_CHAN_W-1:0] chan;
    logic [`SST_CHAN_W-1:0] bypass;
    logic [31:0]            interval;
    logic [31:0]            tmr;
    logic [31:0]            tick;
    logic                   first;
    logic [10:0]            count;
    logic [10:0]            stored;
    logic [AW-1:0]          rd_addr;
    logic [7:0]             pw;
    logic [2:0]             trig_sync;
    logic                   trig_seen;
    logic                   meas_start;
    logic                   trig_out;
    logic                   ack;
    logic [31:0]            rdata;
    logic                   busy;
    logic                   refj;
    logic                   wreq;
  } sst_regs_t;

  sst_regs_t r;
  sst_regs_t next_r;

  // Buffer kept outside the state struct so it maps onto block RAM
  logic [`SST_CHAN_W+`SST_RDG_W-1:0] buf_mem [DEPTH];
  logic [`SST_CHAN_W+`SST_RDG_W-1:0] buf_q;
  logic                              buf_we;

  logic trig_rise;
  logic tmr_done;
  logic last_ch;
  logic acc;

  assign trig_rise = r.trig_sync[1] & ~r.trig_sync[2];
  assign tmr_done  = (r.tmr == 32'h0000_0000);
  assign last_ch   = (r.chan == r.max_ch);
  assign acc       = (av_req_i.read | av_req_i.write) & ~r.ack;

  // Next-state logic: sequencer, timer and register writes
  always_comb begin
    next_r            = r;
    next_r.trig_sync  = {r.trig_sync[1:0], trig_in_i};
    next_r.meas_start = 1'b0;
    next_r.ack        = acc;
    buf_we            = 1'b0;
    if (r.trig_seen == 1'b0 && trig_rise) begin
      next_r.trig_seen = 1'b1;
    end
    // Hundredths-of-second prescaler drives the interval timer
    if (r.tick == 32'(TICK_CYC - 1)) begin
      next_r.tick = 32'h0000_0000;
      if (!tmr_done) begin
        next_r.tmr = r.tmr - 32'h0000_0001;
      end
    end else begin
      next_r.tick = r.tick + 32'h0000_0001;
    end
    // Output pulse width counter, independent of the state machine
    if (r.pw != 8'h00) begin
      next_r.pw = r.pw - 8'h01;
    end else begin
      next_r.trig_out = 1'b0;
    end
    case (r.state)
      SST_IDLE: begin
        next_r.trig_seen = 1'b0;
      end
      SST_WAIT: begin
        // Scan bypass is armed once the source, or in timer mode the interval timer, has released the first channel,
        // so every scan pass, a timed one too, waits only for the release of its first channel
        if (r.bypass != '0) begin
          next_r.bypass     = r.bypass - 1'b1;
          next_r.state      = SST_MEAS;
          next_r.meas_start = 1'b1;
        end else if (r.timer_sel) begin
          if (r.first || tmr_done) begin
            next_r.first      = 1'b0;
            next_r.tmr        = r.interval;
            next_r.tick       = 32'h0000_0000;
            next_r.bypass     = r.step ? '0 : r.max_ch - r.min_ch;
            next_r.state      = SST_MEAS;
            next_r.meas_start = 1'b1;
          end
        end else if (r.trig_seen) begin
          // A trigger landing on the consuming edge is kept for the next pass
          next_r.trig_seen  = trig_rise;
          next_r.bypass     = r.step ? '0 : r.max_ch - r.min_ch;
          next_r.state      = SST_MEAS;
          next_r.meas_start = 1'b1;
        end
      end
      SST_MEAS: begin
        if (meas_done_i) begin
          next_r.state = SST_STORE;
        end
      end
      SST_STORE: begin
        if (r.stored < r.count) begin
          buf_we        = 1'b1;
          next_r.stored = r.stored + 11'h001;
        end
        if (r.step || last_ch) begin
          next_r.trig_out = 1'b1;
          next_r.pw       = 8'(PULSE_CYC - 1);
        end
        next_r.state = SST_PULSE;
      end
      SST_PULSE: begin
        if (r.stored >= r.count) begin
          next_r.state = SST_IDLE;
        end else begin
          next_r.state = SST_WAIT;
          if (last_ch) begin
            next_r.chan = r.min_ch;
          end else begin
            next_r.chan = r.chan + 1'b1;
          end
        end
      end
      default: begin
        next_r.state = SST_IDLE;
      end
    endcase
    // Register writes; halt wins over a start in the same word
    if (acc && av_req_i.write) begin
      case (av_req_i.address)
        `SST_OFF_CTRL: begin
          next_r.timer_sel = av_req_i.writedata[`SST_CTRL_TIMER];
          if (av_req_i.writedata[`SST_CTRL_HALT]) begin
            next_r.state = SST_IDLE;
          end else if (av_req_i.writedata[`SST_CTRL_STEP] ||
                       av_req_i.writedata[`SST_CTRL_SCAN]) begin
            next_r.state     = SST_WAIT;
            next_r.step      = av_req_i.writedata[`SST_CTRL_STEP];
            next_r.chan      = r.min_ch;
            next_r.stored    = 11'h000;
            next_r.first     = 1'b1;
            next_r.trig_seen = 1'b0;
            next_r.bypass    = '0;
          end
        end
        `SST_OFF_CHAN: begin
          next_r.min_ch = av_req_i.writedata[`SST_CHAN_W-1:0];
          next_r.max_ch = av_req_i.writedata[16+:`SST_CHAN_W];
        end
        `SST_OFF_TIMER: begin
          next_r.interval = (av_req_i.writedata > `SST_TIMER_MAX) ? `SST_TIMER_MAX
                            : av_req_i.writedata;
        end
        `SST_OFF_COUNT: begin
          // Whole word compared so a large count clamps instead of wrapping
          next_r.count = (av_req_i.writedata > 32'(`SST_MAX_COUNT)) ? `SST_MAX_COUNT
                         : av_req_i.writedata[10:0];
        end
        `SST_OFF_RDADDR: begin
          next_r.rd_addr = av_req_i.writedata[AW-1:0];
        end
        default: begin
        end
      endcase
    end
    // Read mux; unmapped offsets read as zero
    next_r.rdata = 32'h0000_0000;
    case (av_req_i.address)
      `SST_OFF_CTRL:   next_r.rdata = {28'h0, r.timer_sel, 1'b0, ~r.step, r.step};
      `SST_OFF_CHAN:   next_r.rdata = {8'h00, r.max_ch, 8'h00, r.min_ch};
      `SST_OFF_TIMER:  next_r.rdata = r.interval;
      `SST_OFF_COUNT:  next_r.rdata = {21'h0, r.count};
      `SST_OFF_STATUS: next_r.rdata = {16'h0, r.chan, 3'h0, r.state};
      `SST_OFF_STORED: next_r.rdata = {21'h0, r.stored};
      `SST_OFF_RDADDR: next_r.rdata = 32'(r.rd_addr);
      `SST_OFF_RDDATA: next_r.rdata = {8'h00, buf_q};
      default:         next_r.rdata = 32'h0000_0000;
    endcase
    // Status outputs taken from the next state so that they leave flip-flops
    next_r.busy = (next_r.state != SST_IDLE);
    next_r.refj = next_r.busy && (next_r.chan == 8'h01);
    next_r.wreq = ~acc;
  end

  // State register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      r          <= '0;
      r.state    <= SST_IDLE;
      r.step     <= 1'b1;
      r.min_ch   <= 8'h01;
      r.max_ch   <= 8'h0A;
      r.chan     <= 8'h01;
      r.count    <= 11'h00A;
      r.wreq     <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  // Reading buffer with channel tag; read port is registered
  always_ff @(posedge clk_i) begin
    if (buf_we) begin
      buf_mem[r.stored[AW-1:0]] <= {r.chan, meas_data_i};
    end
    buf_q <= buf_mem[r.rd_addr];
  end

  // Outputs straight from flip-flops
  assign av_rsp_o.readdata    = r.rdata;
  assign av_rsp_o.waitrequest = r.wreq;
  assign trig_out_o           = r.trig_out;
  assign meas_start_o         = r.meas_start;
  assign chan_o               = r.chan;
  assign busy_o               = r.busy;
  // Reference flag only while a step or scan sits on channel 1
  assign ref_junction_o       = r.refj;

  // Checks beside the sequencer; a control write in the same cycle may redirect it
  chk_step_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
    (r.state == SST_STORE && r.step) |=> trig_out_o)
    else $error("step did not pulse the trigger output");
  chk_scan_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
    (r.state == SST_STORE && !r.step && !last_ch && !trig_out_o) |=> !trig_out_o)
    else $error("scan pulsed before the last channel");
  chk_halt_idle: assert property (@(posedge clk_i) disable iff (rst_i)
    (acc && av_req_i.write && av_req_i.address == `SST_OFF_CTRL
     && av_req_i.writedata[`SST_CTRL_HALT]) |=> (r.state == SST_IDLE))
    else $error("halt did not return to idle");
  chk_first_pass: assert property (@(posedge clk_i) disable iff (rst_i)
    (r.state == SST_WAIT && r.timer_sel && r.first && r.bypass == '0)
    |=> (r.state == SST_MEAS))
    else $error("timer first pass waited");
  chk_timer_wait: assert property (@(posedge clk_i) disable iff (rst_i)
    (r.state == SST_WAIT && r.timer_sel && !r.first && !tmr_done && r.bypass == '0)
    |=> (r.state != SST_MEAS))
    else $error("timer detection before interval expired");
  chk_store_limit: assert property (@(posedge clk_i) disable iff (rst_i)
    busy_o |-> (r.stored <= r.count))
    else $error("more readings stored than the reading count");
  chk_pulse_width: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(trig_out_o) |-> trig_out_o[*8] ##1 !trig_out_o)
    else $error("trigger output width wrong");
  chk_chan_range: assert property (@(posedge clk_i) disable iff (rst_i)
    (busy_o && r.min_ch <= r.max_ch) |-> (r.chan >= r.min_ch && r.chan <= r.max_ch))
    else $error("channel outside the scan list");
  chk_bypass_scan: assert property (@(posedge clk_i) disable iff (rst_i)
    (r.state == SST_WAIT && r.bypass != '0 && !(acc && av_req_i.write))
    |=> (r.state == SST_MEAS))
    else $error("scan bypass waited on the source");
  chk_loop_wait: assert property (@(posedge clk_i) disable iff (rst_i)
    (r.state == SST_PULSE && r.stored < r.count && !(acc && av_req_i.write))
    |=> (r.state == SST_WAIT))
    else $error("loop did not return to the source wait");
  chk_count_stop: assert property (@(posedge clk_i) disable iff (rst_i)
    (r.state == SST_PULSE && r.stored >= r.count && !(acc && av_req_i.write))
    |=> !busy_o)
    else $error("sequence ran past the reading count");
endmodule
`default_nettype wire

// ### hdl/sst_cfg.svh
// Constants of the scan/step trigger sequencer: register map, fields and timing
`ifndef SST_CFG_SVH
`define SST_CFG_SVH

`define SST_ADDR_W        4
`define SST_OFF_CTRL      4'h0
`define SST_OFF_CHAN      4'h1
`define SST_OFF_TIMER     4'h2
`define SST_OFF_COUNT     4'h3
`define SST_OFF_STATUS    4'h4
`define SST_OFF_STORED    4'h5
`define SST_OFF_RDADDR    4'h6
`define SST_OFF_RDDATA    4'h7

`define SST_CTRL_STEP     0
`define SST_CTRL_SCAN     1
`define SST_CTRL_HALT     2
`define SST_CTRL_TIMER    3

`define SST_MAX_COUNT     11'h400
`define SST_TICK_NS       10000000
`define SST_CLK_NS        10
`define SST_TICK_CYC      (`SST_TICK_NS / `SST_CLK_NS)
// Longest interval, 99 h 99 min 99.99 s, counted in 10 ms ticks
`define SST_TIMER_MAX     32'h0229_0A1F
`define SST_PULSE_CYC     8
`define SST_CHAN_W        8
`define SST_RDG_W         16

`endif

// ### hdl/sst_pkg.sv
// Types of the scan/step trigger sequencer
`default_nettype none
package sst_pkg;
  typedef enum logic [4:0] {
    SST_IDLE  = 5'h01,
    SST_WAIT  = 5'h02,
    SST_MEAS  = 5'h04,
    SST_STORE = 5'h08,
    SST_PULSE = 5'h10
  } sst_state_t;

  typedef struct packed {
    logic [3:0]  address;
    logic        read;
    logic        write;
    logic [31:0] writedata;
  } sst_av_req_t;

  typedef struct packed {
    logic [31:0] readdata;
    logic        waitrequest;
  } sst_av_rsp_t;
endpackage
`default_nettype wire

// ### tb/sst_mainframe.sv
// Switching mainframe model: closes the next channel and pulses its ready line
`default_nettype none
module sst_mainframe (
  input  wire logic       clk_i,
  input  wire logic       kick_i,
  input  wire logic       trig_out_i,
  input  wire logic [7:0] dly_i,
  output logic            trig_in_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       prev;
  logic [7:0] cnt;
  initial begin
    prev = 1'b0;
    cnt = 8'h00;
    trig_in_o = 1'b0;
  end
  // Relay settling takes dly_i + 1 cycles; the line idles low between closures
  always @(posedge clk_i) begin
    prev <= trig_out_i;
    trig_in_o <= (cnt == 8'h01);
    if (kick_i || (trig_out_i && !prev)) begin
      cnt <= dly_i + 8'h01;
    end else if (cnt != 8'h00) begin
      cnt <= cnt - 8'h01;
    end
  end
endmodule
`default_nettype wire

// ### tb/tb.sv
// Self-checking bench for the scan/step trigger sequencer
`default_nettype none
`include "sst_cfg.svh"
module tb;
  import sst_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  sst_av_req_t req = '0;
  sst_av_rsp_t rsp;
  logic [7:0]  chan;
  logic [7:0]  dly = 8'h02;
  logic [2:0]  md = 3'h0;
  logic [31:0] rd;
  int          errors = 0, samples_checked = 0, cyc = 0, pulses = 0, width = 0, last_w = 0;
  int          since = 0, last_gap = 0;
  logic        clk_i = 1'b0, rst_i = 1'b1, kick = 1'b0, prev = 1'b0, ref_seen = 1'b0;
  logic        trig_in, trig_out, meas_start, ref_j, busy;

  // Short timer tick keeps timed passes brief
  sst_sequencer #(.TICK_CYC(4)) dut (
    .clk_i(clk_i), .rst_i(rst_i), .av_req_i(req), .av_rsp_o(rsp), .trig_in_i(trig_in),
    .trig_out_o(trig_out), .meas_start_o(meas_start), .meas_done_i(md[2]),
    .meas_data_i({8'hA0, chan}), .chan_o(chan), .ref_junction_o(ref_j), .busy_o(busy));
  sst_mainframe mf (.clk_i(clk_i), .kick_i(kick), .trig_out_i(trig_out), .dly_i(dly),
    .trig_in_o(trig_in));

  always #5 clk_i = ~clk_i;

  // Measurement engine answers in three cycles; pulse bookkeeping and hang guard
  always @(posedge clk_i) begin
    md <= {md[1:0], meas_start};
    // Cycles between measurement starts, to time the interval wait
    if (meas_start) begin
      last_gap <= since;
      since    <= 1;
    end else begin
      since <= since + 1;
    end
    prev <= trig_out;
    if (trig_out && !prev) pulses <= pulses + 1;
    width <= trig_out ? width + 1 : 0;
    if (!trig_out && prev) last_w <= width;
    if (ref_j === 1'b1) ref_seen <= 1'b1;
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      errors++;
      end_of_test();
    end
  end

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // One Avalon access; request held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    req <= '{address: a, read: !wr, write: wr, writedata: d};
    @(posedge clk_i);
    while (rsp.waitrequest !== 1'b0) @(posedge clk_i);
    rd = rsp.readdata;
    req <= '0;
    @(posedge clk_i);
  endtask

  task automatic start(input logic [31:0] chn, input logic [31:0] cnt, input logic [31:0] c);
    pulses = 0;
    ref_seen = 1'b0;
    bus(1'b1, `SST_OFF_CHAN, chn);
    bus(1'b1, `SST_OFF_COUNT, cnt);
    bus(1'b1, `SST_OFF_CTRL, c);
    kick <= 1'b1;
    @(posedge clk_i);
    kick <= 1'b0;
  endtask

  task automatic wait_idle();
    while (busy !== 1'b0 || trig_out !== 1'b0) @(posedge clk_i);
  endtask

  task automatic t_regs();
    chk("busy after reset", busy, 0);
    chk("ref idle", ref_j, 0);
    bus(1'b0, `SST_OFF_CHAN, 0);
    chk("chan default", rd, 32'h000A_0001);
    bus(1'b0, `SST_OFF_STATUS, 0);
    chk("status idle", rd, 32'h0000_0101);
    bus(1'b0, 4'h8, 0);
    chk("unmapped read", rd, 32'h0);
    bus(1'b1, `SST_OFF_COUNT, 32'h7FF);
    bus(1'b0, `SST_OFF_COUNT, 0);
    chk("count clamp", rd, 32'h400);
  endtask

  task automatic t_step();
    start(32'h0003_0001, 32'h3, 32'h1);
    wait_idle();
    chk("step pulses", pulses, 3);
    chk("pulse width", last_w, `SST_PULSE_CYC);
    chk("ref junction", ref_seen, 1);
    bus(1'b0, `SST_OFF_STORED, 0);
    chk("step stored", rd, 3);
    bus(1'b1, `SST_OFF_RDADDR, 32'h1);
    bus(1'b0, `SST_OFF_RDDATA, 0);
    bus(1'b0, `SST_OFF_RDDATA, 0);
    chk("entry 1", rd, 32'h0002_A002);
  endtask

  task automatic t_scan();
    start(32'h0004_0001, 32'h4, 32'h2);
    wait_idle();
    chk("scan pulses", pulses, 1);
    bus(1'b0, `SST_OFF_STORED, 0);
    chk("scan stored", rd, 4);
  endtask

  // Slow mainframe so the halt lands between channels
  task automatic t_halt();
    dly <= 8'h60;
    start(32'h000A_0001, 32'hA, 32'h1);
    while (pulses == 0) @(posedge clk_i);
    bus(1'b1, `SST_OFF_CTRL, 32'h4);
    chk("busy after halt", busy, 0);
    bus(1'b0, `SST_OFF_STATUS, 0);
    chk("halt state", rd[4:0], 32'h1);
    dly <= 8'h02;
  endtask

  // No kick: only the timer may pace these passes
  task automatic t_timer();
    bus(1'b1, `SST_OFF_TIMER, 32'h3);
    bus(1'b1, `SST_OFF_CHAN, 32'h0002_0001);
    bus(1'b1, `SST_OFF_COUNT, 32'h2);
    bus(1'b1, `SST_OFF_CTRL, 32'h9);
    wait_idle();
    bus(1'b0, `SST_OFF_STORED, 0);
    chk("timed stored", rd, 2);
    // Three ticks of four cycles, plus the edge that sees the timer run out
    chk("timer gap", last_gap, 3 * 4 + 1);
  endtask

  task automatic end_of_test();
    $display("errors %0d samples_checked %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_regs();
    t_step();
    t_scan();
    t_halt();
    t_timer();
    end_of_test();
  end
endmodule
`default_nettype wire
